// ### hdl/pmdis_defs.svh
// Constants for the peripheral module power-off block
`ifndef PMDIS_DEFS_SVH
`define PMDIS_DEFS_SVH
`define PMDIS_NUM_MODULES 32
`define PMDIS_SEL_W 5
`define PMDIS_PERIPHERAL_CLOCK_NETWORK_GATE_BIT 7
`define PMDIS_NVM_BIT 2
`define PMDIS_OFF_RESET 32'h00000000
`define PMDIS_CLK_HZ 40000000
`define PMDIS_WAKE_NS 25
`define PMDIS_WAKE_CYCLES ((`PMDIS_WAKE_NS * (`PMDIS_CLK_HZ / 1000000) + 999) / 1000)
`define PMDIS_NVM_WAKE_NS 1000
`define PMDIS_NVM_WAKE_CYCLES ((`PMDIS_NVM_WAKE_NS * (`PMDIS_CLK_HZ / 1000000) + 999) / 1000)
`endif

// ### hdl/pmdis_pkg.sv
// Types for the peripheral module power-off block
package pmdis_pkg;
    typedef logic [31:0] pmdis_mask_t;
    typedef logic [7:0] pmdis_byte_t;
    typedef enum logic [1:0] {
        PMDIS_RUN = 2'b00,
        PMDIS_OFF = 2'b01,
        PMDIS_WAKE = 2'b10
    } pmdis_state_t;
endpackage

// ### hdl/pmdis_slot.sv
// Per-module power-off sequencer
`timescale 1ns/10ps
`include "pmdis_defs.svh"
module pmdis_slot
    import pmdis_pkg::*;
#(
    parameter int WAKE = 1
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic off_req,
    output logic clk_en,
    output logic held_rst,
    output logic access_ok
);
    import pmdis_pkg::*;
    pmdis_state_t state;
    logic [10:0] cnt;

    // --------------------------------
    // Sequencer
    // --------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            state <= PMDIS_RUN;
            cnt <= 11'h000;
        end else begin
            case (state)
                PMDIS_RUN: begin
                    if (off_req) begin
                        state <= PMDIS_OFF;
                    end
                end
                PMDIS_OFF: begin
                    if (!off_req) begin
                        state <= PMDIS_WAKE;
                        cnt <= 11'(WAKE);
                    end
                end
                PMDIS_WAKE: begin
                    if (off_req) begin
                        state <= PMDIS_OFF;
                    end else if (cnt <= 11'h001) begin
                        state <= PMDIS_RUN;
                    end else begin
                        cnt <= cnt - 11'h001;
                    end
                end
                default: begin
                    state <= PMDIS_RUN;
                end
            endcase
        end
    end

    // --------------------------------
    // Registered controls
    // --------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            clk_en <= 1'b1;
            held_rst <= 1'b0;
            access_ok <= 1'b1;
        end else begin
            clk_en <= !off_req;
            held_rst <= off_req || (state == PMDIS_OFF);
            access_ok <= !off_req && (state == PMDIS_RUN ||
                (state == PMDIS_WAKE && cnt <= 11'h001));
        end
    end
endmodule

// ### hdl/pmdis_top.sv
// Peripheral module power-off control top level
`timescale 1ns/10ps
`include "pmdis_defs.svh"
module pmdis_top
    import pmdis_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire pmdis_pkg::pmdis_mask_t module_power_off,
    input wire pmdis_pkg::pmdis_mask_t uses_clock_network,
    input wire pmdis_pkg::pmdis_mask_t periph_wr_req,
    input wire pmdis_pkg::pmdis_mask_t periph_rd_req,
    input wire pmdis_pkg::pmdis_byte_t rd_sel_data,
    input wire logic [`PMDIS_SEL_W-1:0] rd_sel,
    output pmdis_pkg::pmdis_mask_t periph_clk_en,
    output pmdis_pkg::pmdis_mask_t periph_rst,
    output pmdis_pkg::pmdis_mask_t periph_wr_en,
    output pmdis_pkg::pmdis_mask_t periph_rd_en,
    output pmdis_pkg::pmdis_mask_t pin_route_select_en,
    output pmdis_pkg::pmdis_byte_t rd_data,
    output logic peripheral_clock_network_en,
    output logic nvm_block_off
);
    import pmdis_pkg::*;
    pmdis_mask_t off_ctl;
    pmdis_mask_t slot_clk;
    pmdis_mask_t slot_rst;
    pmdis_mask_t slot_ok;
    logic peripheral_peripheral_clock_network_gate;

    function automatic logic ok_at(input pmdis_mask_t m, input logic [`PMDIS_SEL_W-1:0] i);
        ok_at = m[i];
    endfunction

    // --------------------------------
    // Control capture
    // --------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            off_ctl <= `PMDIS_OFF_RESET;
        end else begin
            off_ctl <= module_power_off;
        end
    end

    assign peripheral_peripheral_clock_network_gate = off_ctl[`PMDIS_PERIPHERAL_CLOCK_NETWORK_GATE_BIT];

    // --------------------------------
    // Per-module sequencers
    // --------------------------------
    for (genvar g = 0; g < `PMDIS_NUM_MODULES; g++) begin : g_slot
        localparam int WK = (g == `PMDIS_NVM_BIT) ? `PMDIS_NVM_WAKE_CYCLES
                                                   : `PMDIS_WAKE_CYCLES;
        pmdis_slot #(.WAKE(WK)) u_slot (
            .clock(clock),
            .srst(srst),
            .off_req(off_ctl[g] && g != `PMDIS_PERIPHERAL_CLOCK_NETWORK_GATE_BIT),
            .clk_en(slot_clk[g]),
            .held_rst(slot_rst[g]),
            .access_ok(slot_ok[g])
        );
    end

    // --------------------------------
    // Gated outputs
    // --------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            periph_clk_en <= '1;
            periph_rst <= '0;
            peripheral_clock_network_en <= 1'b1;
        end else begin
            periph_clk_en <= slot_clk & ~(uses_clock_network & {32{peripheral_peripheral_clock_network_gate}});
            periph_rst <= slot_rst;
            peripheral_clock_network_en <= !peripheral_peripheral_clock_network_gate;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            periph_wr_en <= '0;
            periph_rd_en <= '0;
            pin_route_select_en <= '1;
            nvm_block_off <= 1'b0;
        end else begin
            periph_wr_en <= periph_wr_req & slot_ok;
            periph_rd_en <= periph_rd_req & slot_ok;
            pin_route_select_en <= slot_ok;
            nvm_block_off <= !slot_ok[`PMDIS_NVM_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= ok_at(slot_ok, rd_sel) ? rd_sel_data : 8'h00;
        end
    end
endmodule

// ### testbench/pmdis_top_chk.sv
// Port assertions for the power-off block
`timescale 1ns/10ps
module pmdis_top_chk
    import pmdis_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire pmdis_pkg::pmdis_mask_t module_power_off,
    input wire pmdis_pkg::pmdis_mask_t uses_clock_network,
    input wire pmdis_pkg::pmdis_mask_t periph_clk_en,
    input wire pmdis_pkg::pmdis_mask_t periph_rst,
    input wire pmdis_pkg::pmdis_mask_t periph_wr_en,
    input wire pmdis_pkg::pmdis_mask_t periph_rd_en,
    input wire pmdis_pkg::pmdis_mask_t pin_route_select_en,
    input wire logic peripheral_clock_network_en,
    input wire logic nvm_block_off
);
    localparam pmdis_mask_t k = 32'hffffff7f;
    pmdis_mask_t h1, h2, h3, h4, held, quiet;
    always_ff @(posedge clock) begin
        if (srst) begin
            {h1, h2, h3, h4} <= '0;
        end else begin
            {h1, h2, h3, h4} <= {module_power_off, h1, h2, h3};
        end
    end
    // Off for four samples, or clear for five
    assign held = module_power_off & h1 & h2 & h3;
    assign quiet = ~(module_power_off | h1 | h2 | h3 | h4);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    reset_state_a: assert property ($past(srst) |-> periph_clk_en == '1 &&
        periph_rst == '0 && peripheral_clock_network_en) else $error("bad reset state");
    off_clock_a: assert property ((periph_clk_en & held & k) == '0) else $error("clk on");
    off_reset_a: assert property ((~periph_rst & held & k) == '0) else $error("no reset");
    off_access_a: assert property (((periph_wr_en | periph_rd_en) & held & k) == '0)
        else $error("access passed");
    route_off_a: assert property ((pin_route_select_en & held & k) == '0)
        else $error("routing active");
    net_gate_a: assert property (held[7] |-> !peripheral_clock_network_en)
        else $error("network runs");
    net_users_a: assert property (held[7] |->
        (periph_clk_en & uses_clock_network & k) == '0) else $error("user clock runs");
    nvm_off_a: assert property (held[2] |-> nvm_block_off) else $error("memory open");
    run_clock_a: assert property (
        (~periph_clk_en & quiet & ~uses_clock_network & k) == '0) else $error("clock stopped");
endmodule

// ### testbench/pmdis_periph.sv
// Behavioural peripherals behind the power-off block
`timescale 1ns/10ps
module pmdis_periph
    import pmdis_pkg::*;
(
    input wire logic clock,
    input wire pmdis_pkg::pmdis_mask_t periph_clk_en,
    input wire pmdis_pkg::pmdis_mask_t periph_rst,
    input wire pmdis_pkg::pmdis_mask_t periph_wr_en,
    input wire logic [4:0] rd_sel,
    output pmdis_pkg::pmdis_byte_t rd_sel_data
);
    pmdis_byte_t regs [32];
    always_ff @(posedge clock) begin
        for (int i = 0; i < 32; i++) begin
            if (periph_rst[i]) begin
                regs[i] <= 8'h00;
            end else if (periph_clk_en[i] && periph_wr_en[i]) begin
                regs[i] <= 8'ha5;
            end
        end
    end
    assign rd_sel_data = regs[rd_sel];
endmodule

// ### testbench/pmdis_test.sv
// Self-checking bench for the power-off block
`timescale 1ns/10ps
module pmdis_test;
    import pmdis_pkg::*;
    logic clock = 0, srst = 1, seen = 0;
    pmdis_mask_t mpo = '0, net = '0, wr = '0, rd = '0, clk_en, rst, wr_en, rd_en, route;
    pmdis_byte_t sel_data, rd_data, e;
    logic [4:0] sel = '0;
    logic net_en, nvm_off;
    int n_errors = 0, checks = 0, cyc = 0, m;
    integer seed = 32'he002;
    pmdis_byte_t q[$];
    initial forever #12.5 clock = ~clock;
    pmdis_top pmdis_top_inst (.clock, .srst, .module_power_off(mpo), .uses_clock_network(net),
        .periph_wr_req(wr), .periph_rd_req(rd), .rd_sel_data(sel_data), .rd_sel(sel),
        .periph_clk_en(clk_en), .periph_rst(rst), .periph_wr_en(wr_en), .periph_rd_en(rd_en),
        .pin_route_select_en(route), .rd_data, .peripheral_clock_network_en(net_en),
        .nvm_block_off(nvm_off));
    pmdis_periph pmdis_periph_inst (.clock, .periph_clk_en(clk_en), .periph_rst(rst),
        .periph_wr_en(wr_en), .rd_sel(sel), .rd_sel_data(sel_data));
    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic step(int n);
        repeat (n) @(posedge clock);
    endtask
    // One access cycle; a read notes its expected data
    task automatic access(int i, logic w, pmdis_byte_t x);
        @(posedge clock);
        sel <= i[4:0];
        wr <= w ? 32'h1 << i : '0;
        rd <= w ? '0 : 32'h1 << i;
        if (!w) q.push_back(x);
        @(posedge clock);
        wr <= '0;
        rd <= '0;
        step(2);
    endtask
    always @(posedge clock) begin
        seen <= |rd;
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            complete_run();
        end
    end
    always @(negedge clock) begin
        if (seen) begin
            e = q.pop_front();
            checks++;
            if (rd_data !== e) begin
                n_errors++;
                $display("[FAIL] t=%0t got %h exp %h", $time, rd_data, e);
            end
        end
    end
    initial begin
        net <= $random(seed);
        step(12);
        srst <= 1'b0;
        for (int k = 0; k < 6; k++) begin
            m = k ? $unsigned($random(seed)) % 31 : 2;
            m = (m == 7) ? 0 : m;
            access(m, 1, 8'h00);
            access(m, 0, 8'ha5);
            mpo <= (32'h1 << m) | (k[0] ? 32'h80 : 32'h0);
            step(4);
            access(m, 1, 8'h00);
            access(m, 0, 8'h00);
            mpo <= '0;
            step(45);
            access(m, 0, 8'h00);
        end
        srst <= 1'b1;
        step(2);
        srst <= 1'b0;
        step(3);
        complete_run();
    end
endmodule
bind pmdis_top pmdis_top_chk pmdis_top_chk_inst (.*);
